/* File: common/clkgen_pkg.sv */
package clkgen_pkg;

	// ==========================================================
	// Register map.
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Control register fields.
	localparam int CTRL_SRC_SELECT_BIT = 0;
	localparam int CTRL_DEPTH_N_BIT = 1;

	// Status register fields.
	localparam int STAT_CPU_CLK_BIT = 0;
	localparam int STAT_PERIPH_CLK_BIT = 1;
	localparam int STAT_READY_BIT = 2;
	localparam int STAT_RESET_BIT = 3;
	localparam int STAT_SYNC_BIT = 4;
	localparam int STAT_COUNT_LSB = 5;

	// ==========================================================
	// Pin synchroniser slots.
	localparam int PIN_COUNT = 9;
	localparam int PIN_EXT_FREQ = 0;
	localparam int PIN_XTAL_A = 1;
	localparam int PIN_XTAL_B = 2;
	localparam int PIN_PHASE_SYNC = 3;
	localparam int PIN_RESET_REQ_N = 4;
	localparam int PIN_READY_ONE = 5;
	localparam int PIN_READY_TWO = 6;
	localparam int PIN_GATE_ONE_N = 7;
	localparam int PIN_GATE_TWO_N = 8;
	localparam logic [PIN_COUNT-1:0] PIN_RESET = 9'h198;

	// ==========================================================
	// Divider: the CPU clock is high in count zero of three.
	localparam logic [1:0] DIV_FIRST = 2'h0;
	localparam logic [1:0] DIV_LAST = 2'h2;

	// Output reset values; system reset is asserted out of reset.
	localparam logic CPU_CLK_RESET = 1'b0;
	localparam logic PERIPH_CLK_RESET = 1'b0;
	localparam logic SYS_RESET_RESET = 1'b1;

	// AHB-Lite encodings.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

endpackage

/* File: verilog/cpu_clock_ready_reset_gen.sv */
`timescale 1ns/10ps
`default_nettype none

module cpu_clock_ready_reset_gen (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic RST,
	// AHB-Lite slave.
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Clock sources.
	input wire logic EXTERNAL_FREQ_IN,
	input wire logic CRYSTAL_PIN_A,
	input wire logic CRYSTAL_PIN_B,
	input wire logic PHASE_SYNC_IN,
	// Ready and reset requests.
	input wire logic BUS_READY_ONE,
	input wire logic BUS_READY_TWO,
	input wire logic READY_GATE_ONE_N,
	input wire logic READY_GATE_TWO_N,
	input wire logic RESET_REQUEST_N,
	// Generated outputs.
	output logic CPU_CLK,
	output logic PERIPH_CLK,
	output logic READY_OUT,
	output logic SYSTEM_RESET,
	output logic OSCILLATOR_TAP
);
	import clkgen_pkg::*;

	// ==========================================================
	// State.
	typedef struct packed {
		logic [PIN_COUNT-1:0] pin_meta;
		logic [PIN_COUNT-1:0] pin_sync;
		logic src_prev;
		logic [1:0] div_count;
		logic cpu_clk;
		logic periph_clk;
		logic stage_one;
		logic ready;
		logic sys_reset;
		logic tap_lvl;
		logic src_select;
		logic depth_n;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic xtal_lvl;
	logic src_lvl;
	logic src_rise;
	logic phase_sync;
	logic ready_req;
	logic cpu_rise;
	logic cpu_fall;
	logic addr_take;
	logic [1:0] div_nxt;
	logic clk_nxt;
	logic [31:0] status_word;

	// Crystal pins act as a differential clock input only.
	assign xtal_lvl = st_r.pin_sync[PIN_XTAL_A] & ~st_r.pin_sync[PIN_XTAL_B];
	assign src_lvl = st_r.src_select ? st_r.pin_sync[PIN_EXT_FREQ] : xtal_lvl;
	// Each source phase must last at least one core cycle, or its edge is lost in the synchroniser.
	assign src_rise = src_lvl & ~st_r.src_prev;
	assign phase_sync = st_r.pin_sync[PIN_PHASE_SYNC];
	assign ready_req = (st_r.pin_sync[PIN_READY_ONE] & ~st_r.pin_sync[PIN_GATE_ONE_N])
		| (st_r.pin_sync[PIN_READY_TWO] & ~st_r.pin_sync[PIN_GATE_TWO_N]);
	assign cpu_rise = ~st_r.cpu_clk & clk_nxt;
	assign cpu_fall = st_r.cpu_clk & ~clk_nxt;
	assign addr_take = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ);

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[STAT_CPU_CLK_BIT] = st_r.cpu_clk;
		status_word[STAT_PERIPH_CLK_BIT] = st_r.periph_clk;
		status_word[STAT_READY_BIT] = st_r.ready;
		status_word[STAT_RESET_BIT] = st_r.sys_reset;
		status_word[STAT_SYNC_BIT] = phase_sync;
		status_word[STAT_COUNT_LSB +: 2] = st_r.div_count;
	end

	// ==========================================================
	// Divider.
	// Divide by three; one high count of three gives 33% high time.
	// Kept out of the main process so the edge strobes never loop back into it.
	always_comb begin
		div_nxt = st_r.div_count;
		clk_nxt = st_r.cpu_clk;
		if (phase_sync) begin
			div_nxt = DIV_FIRST;
			clk_nxt = 1'b1;
		end else if (src_rise) begin
			div_nxt = (st_r.div_count == DIV_LAST) ? DIV_FIRST : st_r.div_count + 2'h1;
			clk_nxt = (st_r.div_count == DIV_LAST);
		end
	end

	// ==========================================================
	// Next state.
	always_comb begin
		st_nxt = st_r;
		// Two flops per pin; only the second stage feeds logic.
		st_nxt.pin_meta = {READY_GATE_TWO_N, READY_GATE_ONE_N, BUS_READY_TWO, BUS_READY_ONE,
			RESET_REQUEST_N, PHASE_SYNC_IN, CRYSTAL_PIN_B, CRYSTAL_PIN_A, EXTERNAL_FREQ_IN};
		st_nxt.pin_sync = st_r.pin_meta;
		st_nxt.src_prev = src_lvl;
		// Tap follows the crystal whichever source drives the divider.
		st_nxt.tap_lvl = xtal_lvl;

		st_nxt.div_count = div_nxt;
		st_nxt.cpu_clk = clk_nxt;

		// Peripheral clock toggles on each CPU clock fall, held high in sync.
		if (phase_sync) begin
			st_nxt.periph_clk = 1'b1;
		end else if (cpu_fall) begin
			st_nxt.periph_clk = ~st_r.periph_clk;
		end

		// Ready changes only on the CPU clock fall so the CPU hold time is kept.
		if (cpu_rise) begin
			st_nxt.stage_one = ready_req;
		end
		if (cpu_fall) begin
			st_nxt.ready = st_r.depth_n ? ready_req : (st_r.stage_one & ready_req);
			st_nxt.sys_reset = ~st_r.pin_sync[PIN_RESET_REQ_N];
		end

		// Bus: zero wait state; reads return a word captured in address phase.
		st_nxt.wr_pend = addr_take & HWRITE;
		if (addr_take) begin
			st_nxt.wr_addr = HADDR[7:0];
			st_nxt.rdata = 32'h0000_0000;
			if (!HWRITE && HADDR[7:0] == CTRL_OFFSET) begin
				st_nxt.rdata[CTRL_SRC_SELECT_BIT] = st_r.src_select;
				st_nxt.rdata[CTRL_DEPTH_N_BIT] = st_r.depth_n;
			end else if (!HWRITE && HADDR[7:0] == STATUS_OFFSET) begin
				st_nxt.rdata = status_word;
			end
		end
		if (st_r.wr_pend && st_r.wr_addr == CTRL_OFFSET) begin
			st_nxt.src_select = HWDATA[CTRL_SRC_SELECT_BIT];
			st_nxt.depth_n = HWDATA[CTRL_DEPTH_N_BIT];
		end

		if (RST) begin
			st_nxt = '0;
			st_nxt.pin_meta = PIN_RESET;
			st_nxt.pin_sync = PIN_RESET;
			st_nxt.cpu_clk = CPU_CLK_RESET;
			st_nxt.periph_clk = PERIPH_CLK_RESET;
			st_nxt.sys_reset = SYS_RESET_RESET;
			st_nxt.src_select = CTRL_RESET[CTRL_SRC_SELECT_BIT];
			st_nxt.depth_n = CTRL_RESET[CTRL_DEPTH_N_BIT];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		st_r <= st_nxt;
	end

	// ==========================================================
	// Outputs.
	assign HRDATA = st_r.rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = HRESP_OKAY;
	assign CPU_CLK = st_r.cpu_clk;
	assign PERIPH_CLK = st_r.periph_clk;
	assign READY_OUT = st_r.ready;
	assign SYSTEM_RESET = st_r.sys_reset;
	assign OSCILLATOR_TAP = st_r.tap_lvl;

	// ==========================================================
	// Checks.
	// Properties watch the registered state, so all but a_sync_no_fall and a_div_range, which has no cause, see their cause a cycle later.
	sequence sync_release;
		phase_sync ##1 !phase_sync;
	endsequence

	sequence first_source_edge;
		!phase_sync && src_rise && st_r.div_count == DIV_FIRST;
	endsequence

	a_sync_holds_clk: assert property (@(posedge CORE_CLK) disable iff (RST)
		phase_sync |=> (st_r.cpu_clk && st_r.div_count == DIV_FIRST))
		else $error("CPU clock not held high during phase sync");

	a_div_high_slot: assert property (@(posedge CORE_CLK) disable iff (RST)
		(!phase_sync && src_rise && st_r.div_count == DIV_LAST) |=> st_r.cpu_clk)
		else $error("CPU clock did not rise at end of divide cycle");

	a_div_low_slots: assert property (@(posedge CORE_CLK) disable iff (RST)
		(!phase_sync && src_rise && st_r.div_count != DIV_LAST) |=> !st_r.cpu_clk)
		else $error("CPU clock high outside its one third slot");

	a_release_start: assert property (@(posedge CORE_CLK) disable iff (RST)
		first_source_edge |=> (st_r.div_count == 2'h1 && !st_r.cpu_clk))
		else $error("Divider did not start on first source edge after sync");

	a_release_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
		sync_release |-> (st_r.cpu_clk && st_r.div_count == DIV_FIRST))
		else $error("Divider moved before the first source edge after sync");

	a_pclk_toggle: assert property (@(posedge CORE_CLK) disable iff (RST)
		(cpu_fall && !phase_sync) |=> (st_r.periph_clk != $past(st_r.periph_clk)))
		else $error("Peripheral clock did not toggle on CPU clock fall");

	a_ready_stage_one: assert property (@(posedge CORE_CLK) disable iff (RST)
		cpu_rise |=> (st_r.stage_one == $past(ready_req)))
		else $error("First ready stage missed the gated request");

	a_ready_double: assert property (@(posedge CORE_CLK) disable iff (RST)
		(cpu_fall && !st_r.depth_n) |=> (st_r.ready == $past(st_r.stage_one & ready_req)))
		else $error("Two-stage ready output wrong");

	a_ready_single: assert property (@(posedge CORE_CLK) disable iff (RST)
		(cpu_fall && st_r.depth_n) |=> (st_r.ready == $past(ready_req)))
		else $error("One-stage ready output wrong");

	a_ready_steady: assert property (@(posedge CORE_CLK) disable iff (RST)
		!cpu_fall |=> $stable(st_r.ready))
		else $error("Ready changed away from a CPU clock fall");

	a_reset_follow: assert property (@(posedge CORE_CLK) disable iff (RST)
		cpu_fall |=> (st_r.sys_reset == !$past(st_r.pin_sync[PIN_RESET_REQ_N])))
		else $error("System reset not the inverted request");

	a_tap_raw: assert property (@(posedge CORE_CLK) disable iff (RST)
		##1 (OSCILLATOR_TAP == $past(xtal_lvl)))
		else $error("Oscillator tap does not follow the crystal");

	a_pclk_sync_high: assert property (@(posedge CORE_CLK) disable iff (RST)
		phase_sync |=> st_r.periph_clk)
		else $error("Peripheral clock not held high during phase sync");

	a_sync_no_fall: assert property (@(posedge CORE_CLK) disable iff (RST)
		phase_sync |-> !cpu_fall)
		else $error("CPU clock fell during phase sync");

	a_clk_steady: assert property (@(posedge CORE_CLK) disable iff (RST)
		(!phase_sync && !src_rise) |=> $stable(st_r.cpu_clk))
		else $error("CPU clock moved without a source edge");

	a_div_range: assert property (@(posedge CORE_CLK) disable iff (RST)
		st_r.div_count <= DIV_LAST)
		else $error("Divide count left its three states");

	a_pclk_steady: assert property (@(posedge CORE_CLK) disable iff (RST)
		(!phase_sync && !cpu_fall) |=> $stable(st_r.periph_clk))
		else $error("Peripheral clock moved away from a CPU clock fall");

	a_stage_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
		!cpu_rise |=> $stable(st_r.stage_one))
		else $error("First ready stage moved away from a CPU clock rise");

	a_ready_drop: assert property (@(posedge CORE_CLK) disable iff (RST)
		(cpu_fall && !ready_req) |=> !st_r.ready)
		else $error("Dropped request did not clear ready at the fall");

	a_ready_needs_rise: assert property (@(posedge CORE_CLK) disable iff (RST)
		(cpu_fall && !st_r.depth_n && !st_r.stage_one) |=> !st_r.ready)
		else $error("Two-stage ready rose without the rise stage");

	a_reset_on_fall: assert property (@(posedge CORE_CLK) disable iff (RST)
		!cpu_fall |=> $stable(st_r.sys_reset))
		else $error("System reset moved away from a CPU clock fall");

	a_ctrl_write: assert property (@(posedge CORE_CLK) disable iff (RST)
		(st_r.wr_pend && st_r.wr_addr == CTRL_OFFSET) |=> (st_r.src_select ==
		$past(HWDATA[CTRL_SRC_SELECT_BIT]) && st_r.depth_n == $past(HWDATA[CTRL_DEPTH_N_BIT])))
		else $error("Control write did not land");

	a_ctrl_read: assert property (@(posedge CORE_CLK) disable iff (RST)
		(addr_take && !HWRITE && HADDR[7:0] == CTRL_OFFSET)
		|=> (st_r.rdata[CTRL_SRC_SELECT_BIT] == $past(st_r.src_select)))
		else $error("Control read returned a stale source select");

endmodule // cpu_clock_ready_reset_gen

`default_nettype wire

/* File: verif/bus_far_side.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Far side: clock sources, phase sync and bus ready devices.
module bus_far_side #(
	parameter int XH = 3,
	parameter int EH = 4
) (
	// Core clock and commands.
	input wire logic clk,
	input wire logic ext_sel,
	input wire logic sync_req,
	input wire logic rdy_a_req,
	input wire logic rdy_b_req,
	input wire logic slow,
	// Pins.
	output var logic ext_clk = 1'b0,
	output var logic xa = 1'b0,
	output var logic xb = 1'b0,
	output var logic psync = 1'b0,
	output var logic rdy_a = 1'b0,
	output var logic rdy_b = 1'b0
);
	int xc = 0;
	int ec = 0;
	int dly = 0;
	always @(posedge clk) begin
		xc <= (xc == 2*XH-1) ? 0 : xc + 1;
		ec <= (ec == 2*EH-1) ? 0 : ec + 1;
		xa <= (xc < XH);
		xb <= 1'b0;
		ext_clk <= (ec < EH);
		// Sync moves as the source falls, half a period clear of its rising edge.
		if (ec == EH) psync <= sync_req & ext_sel;
		dly <= (rdy_a_req | rdy_b_req) ? dly + 1 : 0;
		// A slow device raises ready late; dropping it is always prompt.
		rdy_a <= rdy_a_req & (!slow | dly > 20);
		rdy_b <= rdy_b_req & (!slow | dly > 20);
	end
endmodule // bus_far_side
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench.
module tb_top;
	import clkgen_pkg::*;
	localparam int XH = 3;
	localparam int EH = 4;
	localparam logic [31:0] CA = {24'h0, CTRL_OFFSET};
	localparam logic [31:0] SA = {24'h0, STATUS_OFFSET};
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, ext = 0, sreq = 0;
	logic r1 = 0, r2 = 0, g1 = 1, g2 = 1, rreq_n = 0, slow = 0, c1 = 0, c2 = 0, rd = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, seed = 32'h7b6a, v;
	wire logic [31:0] hrdata;
	wire logic hrdy, hresp, ext_clk, xa, xb, ps, b1, b2, cpu, pclk, rdy, sres, tap;
	int num_errors = 0, checks_done = 0, hi, lo;
	initial forever #4 clk = ~clk;
	cpu_clock_ready_reset_gen dut (.CORE_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
		.HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .EXTERNAL_FREQ_IN(ext_clk),
		.CRYSTAL_PIN_A(xa), .CRYSTAL_PIN_B(xb), .PHASE_SYNC_IN(ps), .BUS_READY_ONE(b1),
		.BUS_READY_TWO(b2), .READY_GATE_ONE_N(g1), .READY_GATE_TWO_N(g2),
		.RESET_REQUEST_N(rreq_n), .CPU_CLK(cpu), .PERIPH_CLK(pclk), .READY_OUT(rdy),
		.SYSTEM_RESET(sres), .OSCILLATOR_TAP(tap));
	bus_far_side #(.XH(XH), .EH(EH)) fs (.clk(clk), .ext_sel(ext), .sync_req(sreq),
		.rdy_a_req(r1), .rdy_b_req(r2), .slow(slow), .ext_clk(ext_clk), .xa(xa), .xb(xb),
		.psync(ps), .rdy_a(b1), .rdy_b(b2));
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function logic sig(input int s);
		return (s == 0) ? cpu : ((s == 1) ? pclk : tap);
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		q = hrdata;
		check(hresp, HRESP_OKAY);
	endtask
	task meas(input int s);
		hi = 0;
		lo = 0;
		@(negedge clk);
		while (sig(s) !== 1'b0) @(negedge clk);
		while (sig(s) !== 1'b1) @(negedge clk);
		while (sig(s) === 1'b1) begin
			hi++;
			@(negedge clk);
		end
		while (sig(s) === 1'b0) begin
			lo++;
			@(negedge clk);
		end
	endtask
	task summarize();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Ready may only move just after a falling CPU clock, so the CPU hold time is kept.
	always @(negedge clk) begin
		if (!rst && rdy !== rd) check({31'h0, (c2 & !c1) | (c1 & !cpu)}, 32'h1);
		c2 = c1;
		c1 = cpu;
		rd = rdy;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check(sres, SYS_RESET_RESET);
		ahb(1'b0, CA, 32'h0);
		check(q, CTRL_RESET);
		ahb(1'b0, 32'h8, 32'h0);
		check(q, 32'h0);
		rreq_n <= 1'b1;
		meas(0);
		check(hi, 2*XH);
		check(lo, 4*XH);
		meas(1);
		check(hi, 6*XH);
		check(lo, 6*XH);
		check(sres, 1'b0);
		ahb(1'b1, CA, 32'h1);
		ext <= 1'b1;
		ahb(1'b0, CA, 32'h0);
		check(q, 32'h1);
		repeat (60) @(posedge clk);
		meas(0);
		check(hi, 2*EH);
		check(lo, 4*EH);
		meas(2);
		check(hi, XH);
		check(lo, XH);
		@(posedge clk);
		sreq <= 1'b1;
		repeat (60) @(posedge clk);
		repeat (8) @(negedge clk) check({cpu, pclk}, 2'h3);
		ahb(1'b0, SA, 32'h0);
		check(q, (32'h1 << STAT_CPU_CLK_BIT) | (32'h1 << STAT_PERIPH_CLK_BIT) | (32'h1 << STAT_SYNC_BIT));
		ahb(1'b1, SA, 32'hffff_ffff);
		ahb(1'b0, CA, 32'h0);
		check(q, 32'h1);
		@(posedge clk);
		sreq <= 1'b0;
		meas(0);
		check(hi, 2*EH);
		check(lo, 4*EH);
		q = xs();
		for (int d = 0; d < 2; d++) begin
			ahb(1'b1, CA, {30'h0, d[0], 1'b1});
			for (int i = 0; i < 16; i++) begin
				v = i ^ q;
				r1 <= v[0];
				r2 <= v[1];
				g1 <= v[2];
				g2 <= v[3];
				slow <= ^xs();
				repeat (100) @(posedge clk);
				check(rdy, (v[0] & !v[2]) | (v[1] & !v[3]));
			end
		end
		// Single master on ready two: only its gate is low, so ready one must not count.
		g1 <= 1'b1;
		g2 <= 1'b0;
		r1 <= 1'b1;
		r2 <= 1'b0;
		repeat (100) @(posedge clk);
		check(rdy, 1'b0);
		r2 <= 1'b1;
		repeat (100) @(posedge clk);
		check(rdy, 1'b1);
		rreq_n <= 1'b0;
		repeat (100) @(posedge clk);
		check(sres, 1'b1);
		rreq_n <= 1'b1;
		repeat (100) @(posedge clk);
		check(sres, 1'b0);
		summarize();
	end
endmodule // tb_top
`default_nettype wire
